// File: rtl/tmf_pkg.sv
// Purpose: Shared constants and types for timer mode and pulse output block
// Assumes: Single system oscillator clock drives all logic
// Notes:   Divider ratios are powers of two, held as tap positions
package tmf_pkg;

	// ==================================================
	// Register widths and reset values
	localparam int unsigned TMF_MODE_W  = 4;
	localparam int unsigned TMF_WAVE_W  = 8;
	localparam logic [3:0]  TMF_MODE_RST = 4'h0;
	localparam logic [7:0]  TMF_WAVE_RST = 8'h00;

	// ==================================================
	// Field positions, timer0_mode
	localparam int unsigned T0_BASE_BIT = 0;
	localparam int unsigned T0_RUN_BIT  = 3;
	// Field positions, timer1_mode
	localparam int unsigned T1_BASE_BIT = 0;
	localparam int unsigned T1_SRC_BIT  = 1;
	localparam int unsigned T1_OUT_BIT  = 2;
	localparam int unsigned T1_RUN_BIT  = 3;
	// Field positions, pulse_waveform_select
	localparam int unsigned WV_CAR_LSB  = 6;
	localparam int unsigned WV_MOD_W    = 6;

	// ==================================================
	// Prescaler: counter width and tap bits (tap k gives Fosc/2^(k+1))
	localparam int unsigned TMF_DIV_W   = 15;
	localparam int unsigned TAP_DIV4    = 1;
	localparam int unsigned TAP_DIV8    = 2;
	localparam int unsigned TAP_DIV16   = 3;
	localparam int unsigned TAP_DIV64   = 5;
	localparam int unsigned TAP_DIV1024 = 9;
	// Modulating taps, bit 0 upward: /256 /512 /4096 /8192 /16384 /32768
	localparam int unsigned TAP_MOD [WV_MOD_W] = '{7, 8, 11, 12, 13, 14};

	// Carrier selection codes
	typedef enum logic [1:0] {
		TMF_CAR_LOW  = 2'b00,
		TMF_CAR_HIGH = 2'b01,
		TMF_CAR_D16  = 2'b10,
		TMF_CAR_D8   = 2'b11
	} tmf_car_t;

	// Timer control bundle handed to the counters
	typedef struct packed {
		logic t0_tick;
		logic t0_run;
		logic t1_tick;
		logic t1_run;
	} tmf_timer_ctl_t;

endpackage : tmf_pkg

// File: rtl/tmf_edge_tick.sv
// Purpose: One-cycle tick on each falling edge of a divider tap
// Assumes: Tap input is synchronous to clk
// Notes:   Used once per divided or pin timebase so those ticks share one form
`timescale 1ns/1ns
`default_nettype none
module tmf_edge_tick
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level_in,
	output logic      tick
);
	logic level_r;

	// ==================================================
	// Previous level, for falling edge detect
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			level_r <= 1'b0;
		else
			level_r <= level_in;
	end

	assign tick = level_r & ~level_in;
endmodule : tmf_edge_tick
`default_nettype wire

// File: rtl/tmf_top.sv
// Contract
// RL1 - timer0_mode bit0 picks Fosc/4 or Fosc/1024
// RL2 - timer0_mode bits 1-2 have no effect
// RL3 - timer0_mode bit3 runs or holds timer 0
// RL4 - timer1_mode bit0 picks Fosc or Fosc/64
// RL5 - timer1_mode bit1 picks internal or pin clock
// RL6 - timer1_mode bit2 picks pulse pin source
// RL7 - timer1_mode bit3 runs or holds timer 1
// RL8 - waveform load stores eight bits, drives pin
// RL9 - top two bits pick carrier
// RL10 - low six bits enable modulating frequencies
// RL11 - mode loads are single cycle immediates
// RL12 - carrier gated by enabled modulators, else plain
// RL13 - all mode registers clear at reset
//
// Purpose: Mode registers, timer timebases and pulse output generator
// Assumes: Core presents load strobes with immediate data, one cycle each
// Notes:   Timer counters live outside; they consume timer_ctl ticks
`timescale 1ns/1ns
`default_nettype none
module tmf_top
	import tmf_pkg::*;
#(
	parameter int unsigned DIV_W = TMF_DIV_W
)
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  load_timer0_mode,
	input  wire logic                  load_timer1_mode,
	input  wire logic                  load_pulse_waveform,
	input  wire logic [TMF_WAVE_W-1:0] load_data,
	input  wire logic                  ext_count_input,
	input  wire logic                  t1_freq_in,
	output tmf_timer_ctl_t             timer_ctl,
	output logic                       pulse_out,
	output logic [TMF_MODE_W-1:0]      timer0_mode_q,
	output logic [TMF_MODE_W-1:0]      timer1_mode_q
);
	// ==================================================
	// Elaboration checks
	// The divider must reach the slowest modulating tap; a shorter one
	// would leave the top modulating enables driving a stuck level.
	if (DIV_W < TMF_DIV_W)
		$error("tmf_top: DIV_W too small for divide-by-32768 tap");

	// Timer taps must sit inside the divider
	if (TAP_DIV1024 >= DIV_W || TAP_DIV64 >= DIV_W)
		$error("tmf_top: slow timer tap outside divider");

	if (TAP_DIV4 >= DIV_W)
		$error("tmf_top: fast timer tap outside divider");

	// Carrier taps must sit inside the divider
	if (TAP_DIV16 >= DIV_W || TAP_DIV8 >= DIV_W)
		$error("tmf_top: carrier tap outside divider");

	// Each modulating tap must sit inside the divider
	for (genvar g = 0; g < WV_MOD_W; g++)
	begin : g_mod_tap_chk
		if (TAP_MOD[g] >= DIV_W)
			$error("tmf_top: modulating tap outside divider");
	end

	// Carrier code sits on top of the modulating enables
	if (WV_CAR_LSB + $bits(tmf_car_t) != TMF_WAVE_W)
		$error("tmf_top: carrier field does not end at the top bit");

	if (WV_MOD_W != WV_CAR_LSB)
		$error("tmf_top: modulating enables do not fill the low bits");

	// Run bits are the highest decoded mode fields
	if (TMF_MODE_W <= T0_RUN_BIT || TMF_MODE_W <= T1_RUN_BIT)
		$error("tmf_top: mode register too narrow for run bit");

	// Mode loads take the low bits of the shared immediate
	if (TMF_MODE_W > TMF_WAVE_W)
		$error("tmf_top: mode register wider than load data");

	logic [TMF_MODE_W-1:0] timer0_mode_r;
	logic [TMF_MODE_W-1:0] timer1_mode_r;
	logic [TMF_WAVE_W-1:0] pulse_waveform_select_r;
	logic [DIV_W-1:0]      div_r;
	logic                  t0_slow;
	logic                  t0_run_en;
	logic                  t1_slow;
	logic                  t1_ext_src;
	logic                  t1_out_timer;
	logic                  t1_run_en;
	logic                  t0_base_tick;
	logic                  t0_tick_r;
	logic                  t0_run_r;
	logic                  t1_tick_r;
	logic                  t1_run_r;
	logic                  ext_fall;
	logic                  t0_tick_d4;
	logic                  t0_tick_d1024;
	logic                  t1_tick_d64;
	logic                  t1_base_tick;
	logic                  t1_tick;
	logic                  carrier;
	logic                  mod_gate;
	logic [WV_MOD_W-1:0]   mod_en;
	logic                  wave;
	logic                  pulse_nxt;
	logic                  pulse_r;
	tmf_car_t              car_sel;

	// ==================================================
	// Mode registers
	// RL11 single cycle loads
	// RL13 cleared at reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timer0_mode_r <= TMF_MODE_RST;
		else if (load_timer0_mode)
			timer0_mode_r <= load_data[TMF_MODE_W-1:0];
	end

	// RL11 single cycle loads
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timer1_mode_r <= TMF_MODE_RST;
		else if (load_timer1_mode)
			timer1_mode_r <= load_data[TMF_MODE_W-1:0];
	end

	// RL8 store eight bit waveform
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pulse_waveform_select_r <= TMF_WAVE_RST;
		else if (load_pulse_waveform)
			pulse_waveform_select_r <= load_data;
	end

	assign timer0_mode_q = timer0_mode_r;
	assign timer1_mode_q = timer1_mode_r;

	// ==================================================
	// Mode field decode
	// Only the base and run fields of timer0_mode are named here; the two
	// reserved bits are kept for read-back but nothing below looks at them.
	// RL1 timer 0 base field
	assign t0_slow      = timer0_mode_r[T0_BASE_BIT];
	// RL3 timer 0 run field
	assign t0_run_en    = timer0_mode_r[T0_RUN_BIT];
	// RL4 timer 1 base field
	assign t1_slow      = timer1_mode_r[T1_BASE_BIT];
	// RL5 timer 1 source field
	assign t1_ext_src   = timer1_mode_r[T1_SRC_BIT];
	// RL6 pulse pin source field
	assign t1_out_timer = timer1_mode_r[T1_OUT_BIT];
	// RL7 timer 1 run field
	assign t1_run_en    = timer1_mode_r[T1_RUN_BIT];

	// ==================================================
	// Free running prescaler shared by the divided timebases, the carrier and the modulators
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	// Tap falling edges become single-cycle ticks
	tmf_edge_tick u_tick_d4
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.level_in (div_r[TAP_DIV4]),
		.tick     (t0_tick_d4)
	);

	tmf_edge_tick u_tick_d1024
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.level_in (div_r[TAP_DIV1024]),
		.tick     (t0_tick_d1024)
	);

	tmf_edge_tick u_tick_d64
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.level_in (div_r[TAP_DIV64]),
		.tick     (t1_tick_d64)
	);

	// External count pin, falling edge counts
	tmf_edge_tick u_tick_ext
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.level_in (ext_count_input),
		.tick     (ext_fall)
	);

	// ==================================================
	// Timer timebases
	// Both timer 0 taps run all the time; the field only steers the mux
	// RL1 timer 0 base select
	assign t0_base_tick = t0_slow ? t0_tick_d1024 : t0_tick_d4;

	// Timer 1 base: Fosc means a tick every cycle
	// RL4 internal base select
	assign t1_base_tick = t1_slow ? t1_tick_d64 : 1'b1;

	// RL5 internal or pin source
	assign t1_tick = t1_ext_src ? ext_fall : t1_base_tick;

	// ==================================================
	// Timer control outputs
	// Registered so the counters outside see clean one-cycle ticks; a base
	// change may drop or add one tick at the switch, which a timer being
	// reprogrammed cannot tell apart from its own phase.
	// RL2 reserved bits: only the timer 0 base and run fields reach the timer 0 flops
	// RL1 timer 0 tick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			t0_tick_r <= 1'b0;
		else
			t0_tick_r <= t0_base_tick;
	end

	// RL3 timer 0 run level
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			t0_run_r <= 1'b0;
		else
			t0_run_r <= t0_run_en;
	end

	// RL5 timer 1 tick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			t1_tick_r <= 1'b0;
		else
			t1_tick_r <= t1_tick;
	end

	// RL7 timer 1 run level
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			t1_run_r <= 1'b0;
		else
			t1_run_r <= t1_run_en;
	end

	// Gathered into the bundle the counters consume
	assign timer_ctl = '{
		t0_tick: t0_tick_r,
		t0_run:  t0_run_r,
		t1_tick: t1_tick_r,
		t1_run:  t1_run_r
	};

	// ==================================================
	// Pulse generator carrier
	assign car_sel = tmf_car_t'(
		pulse_waveform_select_r[WV_CAR_LSB +: $bits(tmf_car_t)]);

	// RL9 carrier select
	always_comb
	begin
		unique case (car_sel)
			TMF_CAR_LOW:  carrier = 1'b0;
			TMF_CAR_HIGH: carrier = 1'b1;
			TMF_CAR_D16:  carrier = div_r[TAP_DIV16];
			TMF_CAR_D8:   carrier = div_r[TAP_DIV8];
		endcase
	end

	// RL10 modulator enables
	assign mod_en = pulse_waveform_select_r[WV_MOD_W-1:0];

	// Modulators OR together; carrier passes while any enabled one is high
	always_comb
	begin
		mod_gate = 1'b0;
		for (int i = 0; i < WV_MOD_W; i++)
			mod_gate = mod_gate | (mod_en[i] & div_r[TAP_MOD[i]]);
	end

	// RL12 gated or plain carrier
	assign wave = (|mod_en) ? (carrier & mod_gate) : carrier;

	// RL6 pin source select
	// RL8 waveform when bit2 low
	// The timer frequency is taken as a level; its own phase is kept
	assign pulse_nxt = t1_out_timer ? t1_freq_in : wave;

	// Registered so the pin never glitches across the select mux
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pulse_r <= 1'b0;
		else
			pulse_r <= pulse_nxt;
	end

	assign pulse_out = pulse_r;
endmodule : tmf_top
`default_nettype wire

// File: test/tmf_properties.sv
// Purpose: Assertions on mode loads, ticks and the pulse pin
// Assumes: One clock, async active-low reset
// Notes:   Waveform register is write-only, so a shadow is kept here
`timescale 1ns/1ns
`default_nettype none
module tmf_properties
	import tmf_pkg::*;
(
	input wire logic           clk,
	input wire logic           rst_n,
	input wire logic           load_timer1_mode,
	input wire logic           load_pulse_waveform,
	input wire logic [7:0]     load_data,
	input wire logic           ext_count_input,
	input wire logic           t1_freq_in,
	input wire tmf_timer_ctl_t timer_ctl,
	input wire logic           pulse_out,
	input wire logic [3:0]     timer0_mode_q,
	input wire logic [3:0]     timer1_mode_q
);
	logic [7:0] wave_r;
	// Shadow copy of the waveform value
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			wave_r <= 8'h00;
		else if (load_pulse_waveform)
			wave_r <= load_data;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Assertions
	a_mode_load: assert property (load_timer1_mode |=>
		timer1_mode_q == $past(load_data[3:0])) else $error("mode load");
	a_run_follow: assert property (timer_ctl.t0_run ==
		$past(timer0_mode_q[3]) && timer_ctl.t1_run == $past(timer1_mode_q[3]))
		else $error("run level");
	// Past reset guard avoids the first tick after release
	a_t0_fast: assert property ((!timer0_mode_q[0] && $past(rst_n, 8))[*8]
		##0 timer_ctl.t0_tick |-> $past(timer_ctl.t0_tick, 4)
		&& !$past(timer_ctl.t0_tick)) else $error("t0 fast period");
	a_t0_slow: assert property ((timer0_mode_q[0])[*8] ##0
		timer_ctl.t0_tick |-> !$past(timer_ctl.t0_tick, 4)) else $error("t0 slow");
	a_t1_fast: assert property ((timer1_mode_q[1:0] == 2'h0)[*4]
		|-> timer_ctl.t1_tick) else $error("t1 every cycle");
	a_ext_tick: assert property (timer1_mode_q[1] &&
		$fell(ext_count_input) |-> ##[1:3] timer_ctl.t1_tick) else $error("ext");
	a_pulse_timer: assert property (timer1_mode_q[2] |=>
		pulse_out == $past(t1_freq_in)) else $error("pulse from timer");
	a_wave_const: assert property (!timer1_mode_q[2] && !wave_r[7] &&
		wave_r[5:0] == 6'h00 |=> pulse_out == $past(wave_r[6])) else $error("wave");
endmodule : tmf_properties
bind tmf_top tmf_properties i_props (.clk(clk), .rst_n(rst_n),
	.load_timer1_mode(load_timer1_mode), .load_data(load_data),
	.load_pulse_waveform(load_pulse_waveform), .t1_freq_in(t1_freq_in),
	.ext_count_input(ext_count_input), .timer_ctl(timer_ctl),
	.pulse_out(pulse_out), .timer0_mode_q(timer0_mode_q),
	.timer1_mode_q(timer1_mode_q));
`default_nettype wire

// File: test/tmf_core_model.sv
// Purpose: Core side issuing immediate mode loads
// Assumes: Strobes change at the falling edge
// Notes:   Immediate is scrambled once released
`timescale 1ns/1ns
`default_nettype none
module tmf_core_model
(
	input  wire logic  clk,
	output logic [2:0] ld,
	output logic [7:0] data
);
	initial
	begin
		ld = 3'h0;
		data = 8'h00;
	end
	task automatic load(input logic [2:0] which, input logic [7:0] d);
		@(negedge clk);
		ld = which;
		data = d;
		@(negedge clk);
		ld = 3'h0;
		data = ~d;
	endtask : load
endmodule : tmf_core_model
`default_nettype wire

// File: test/tb.sv
// Purpose: Directed bench for mode registers and pulse pin
// Assumes: 100 MHz clock, reset held six cycles
// Notes:   Counts are taken over whole divider periods
`timescale 1ns/1ns
`default_nettype none
module tb;
	import tmf_pkg::*;
	logic clk, rst_n, ext, t1f, po;
	logic [2:0] ld;
	logic [7:0] d;
	logic [3:0] q0, q1;
	tmf_timer_ctl_t ctl;
	int num_errors = 0, checks = 0, cyc = 0, t0n, t1n, hin, rsn, n;
	tmf_top i_dut (.clk(clk), .rst_n(rst_n), .load_timer0_mode(ld[0]),
		.load_timer1_mode(ld[1]), .load_pulse_waveform(ld[2]), .load_data(d),
		.ext_count_input(ext), .t1_freq_in(t1f), .timer_ctl(ctl),
		.pulse_out(po), .timer0_mode_q(q0), .timer1_mode_q(q1));
	tmf_core_model i_core (.clk(clk), .ld(ld), .data(d));
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task automatic final_report();
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// Hang guard, well above the planned run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			num_errors++;
			final_report();
		end
	end
	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s exp %0d got %0d", nm, exp, got);
		end
	endtask : chk
	// Skip s cycles, then count ticks, highs and rises over n cycles
	task automatic meas(input int s, input int n);
		logic p;
		repeat (s) @(negedge clk);
		{t0n, t1n, hin, rsn} = 0;
		p = po;
		repeat (n)
		begin
			@(negedge clk);
			t0n += ctl.t0_tick;
			t1n += ctl.t1_tick;
			hin += po;
			rsn += po & !p;
			p = po;
		end
	endtask : meas
	initial
	begin
		{rst_n, t1f} = 0;
		ext = 1;
		repeat (6) @(negedge clk);
		rst_n = 1;
		chk("mode", {ctl, po, q0, q1}, 0);
		t1f = 1;
		i_core.load(3'h3, 8'h06);
		chk("q0", q0, 6);
		chk("q1", q1, 6);
		meas(4, 64);
		chk("t0 reserved", t0n, 16);
		chk("t1 ext idle", t1n, 0);
		chk("pulse timer", hin, 64);
		n = 0;
		repeat (5)
		begin
			ext = 0;
			meas(0, 4);
			n += t1n;
			ext = 1;
			meas(0, 4);
			n += t1n;
		end
		chk("t1 ext", n, 5);
		i_core.load(3'h3, 8'h89);
		meas(4, 2048);
		chk("t0 slow", t0n, 2);
		chk("t1 slow", t1n, 32);
		chk("runs", {ctl.t0_run, ctl.t1_run}, 3);
		i_core.load(3'h3, 8'h00);
		meas(4, 64);
		chk("t0 fast", t0n, 16);
		chk("t1 fast", t1n, 64);
		chk("stops", {ctl.t0_run, ctl.t1_run}, 0);
		chk("wave low", hin, 0);
		for (int c = 0; c < 4; c++)
		begin
			i_core.load(3'h4, 8'(c << 6));
			meas(4, 64);
			chk("car hi", hin, c == 0 ? 0 : c == 1 ? 64 : 32);
			chk("car rise", rsn, c < 2 ? 0 : c * 4 - 4);
		end
		for (int b = 0; b < 4; b++)
		begin
			i_core.load(3'h4, 8'h40 | 8'(1 << b));
			meas(4, 8192);
			chk("mod bit", hin, 4096);
		end
		i_core.load(3'h4, 8'h70);
		meas(4, 32768);
		chk("mod or", hin, 24576);
		i_core.load(3'h4, 8'hC1);
		meas(4, 256);
		chk("mod and", hin, 64);
		final_report();
	end
endmodule : tb
`default_nettype wire
